//--- src/wdg_defs.vh
// Register map, field positions and timing constants of the watchdog block.
`ifndef WDG_DEFS_VH
`define WDG_DEFS_VH

// -----------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------
`define WDG_CTRL_ADDR      8'h80
`define WDG_STAT_ADDR      8'h84
`define WDG_ADDR_W         8

// -----------------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------------
`define WDG_EN_BIT         7
`define WDG_KICK_BIT       6
`define WDG_DDC_CLR_BIT    5
`define WDG_DIV_OPT_BIT    4
`define WDG_IVL_HI         2
`define WDG_IVL_LO         0

// -----------------------------------------------------------------------
// Reset values and timing
// -----------------------------------------------------------------------
`define WDG_IVL_RST        3'h0
`define WDG_CLK_HZ         250000000
`define WDG_TICK_MS        250
`define WDG_TICK_CYC       ((`WDG_CLK_HZ / 1000) * `WDG_TICK_MS)
`define WDG_ZERO_STEPS     4'h8

`endif

//--- src/wdg_prescale.v
// Quarter-second tick generator for the watchdog.
`timescale 1ns/100ps
`include "wdg_defs.vh"

module wdg_prescale #(
    parameter DIV = `WDG_TICK_CYC
) (
    // Clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // Control
    input  wire restart_i,
    input  wire run_i,
    // Tick
    output wire tick_o
);

    reg  [31:0] cnt_r;
    wire        last = (cnt_r == DIV - 1);

    assign tick_o = run_i & last;

    // A restart realigns the time base, so a kick grants a full period.
    always @(posedge clk_i) begin
        if (rst_i || restart_i || !run_i || last) begin
            cnt_r <= 32'h0;
        end else begin
            cnt_r <= cnt_r + 32'h1;
        end
    end

endmodule

//--- src/wdg_top.v
// Watchdog timer with Wishbone control register and chip reset output.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "wdg_defs.vh"

// How it works
// - Control register at 80h: enable, kick, flag clear, option, interval.
// - Writing enable one starts the watchdog counting toward overflow.
// - Writing kick one restarts the count from zero.
// - Writing flag clear one clears the bidirectional display-channel flag.
// - Interval zero overflows after eight quarter-second periods.
// - Interval N from one to seven overflows after N quarter seconds.
// - Overflow asserts a reset of the whole chip.
// - After power-on reset the watchdog stays disabled until enabled.
module wdg_top #(
    parameter TICK_DIV = `WDG_TICK_CYC
) (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // Wishbone slave
    input  wire       cyc_i,
    input  wire       stb_i,
    input  wire       we_i,
    input  wire [7:0] adr_i,
    input  wire [3:0] sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg        ack_o,
    output reg        err_o,
    // Display channel mode flag
    input  wire       ddc2_set_i,
    output reg        ddc2_flag_o,
    // Chip reset request
    output reg        chip_rst_o,
    // Stored divider option
    output wire       divider_option_o
);

    // -------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------
    reg        enable_r;
    reg        div_opt_r;
    reg  [2:0] interval_select_r;
    reg  [3:0] steps_r;

    wire req      = cyc_i & stb_i & ~ack_o & ~err_o;
    wire hit_ctrl = (adr_i == `WDG_CTRL_ADDR);
    wire hit_stat = (adr_i == `WDG_STAT_ADDR);
    wire wr_ctrl  = req & we_i & hit_ctrl & sel_i[0];
    wire wd_kick  = wr_ctrl & dat_i[`WDG_KICK_BIT];
    wire ddc2_flag_clear = wr_ctrl & dat_i[`WDG_DDC_CLR_BIT];

    // Interval zero means eight steps.
    wire [3:0] limit = (interval_select_r == 3'h0) ? `WDG_ZERO_STEPS :
                       {1'b0, interval_select_r};
    wire       tick;

    assign divider_option_o = div_opt_r;

    // -------------------------------------------------------------------
    // Time base
    // -------------------------------------------------------------------
    wdg_prescale #(
        .DIV       (TICK_DIV)
    ) u_pre (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restart_i (wd_kick),
        .run_i     (enable_r),
        .tick_o    (tick)
    );

    // -------------------------------------------------------------------
    // Bus slave: one wait-free answer the cycle after the request.
    // -------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= req & (hit_ctrl | (hit_stat & ~we_i));
            err_o <= req & ~(hit_ctrl | (hit_stat & ~we_i));
            // The control register is write-only and reads as zero.
            if (req && hit_stat && !we_i) begin
                dat_o <= {28'h0, chip_rst_o, ddc2_flag_o, div_opt_r,
                          enable_r};
            end else begin
                dat_o <= 32'h0;
            end
        end
    end

    // -------------------------------------------------------------------
    // Control register
    // -------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            enable_r          <= 1'b0;
            div_opt_r         <= 1'b0;
            interval_select_r <= `WDG_IVL_RST;
        end else if (wr_ctrl) begin
            enable_r          <= dat_i[`WDG_EN_BIT];
            div_opt_r         <= dat_i[`WDG_DIV_OPT_BIT];
            interval_select_r <= dat_i[`WDG_IVL_HI:`WDG_IVL_LO];
        end
    end

    // -------------------------------------------------------------------
    // Mode flag: a set in the clear cycle wins.
    // -------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            ddc2_flag_o <= 1'b0;
        end else if (ddc2_set_i) begin
            ddc2_flag_o <= 1'b1;
        end else if (ddc2_flag_clear) begin
            ddc2_flag_o <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Step counter and overflow
    // -------------------------------------------------------------------
    // The chip reset pulse is one cycle; the system reset tree is expected
    // to stretch it and feed it back into rst_i.
    always @(posedge clk_i) begin
        if (rst_i) begin
            steps_r    <= 4'h0;
            chip_rst_o <= 1'b0;
        end else begin
            chip_rst_o <= 1'b0;
            if (wd_kick || !enable_r) begin
                steps_r <= 4'h0;
            end else if (tick) begin
                if (steps_r + 4'h1 >= limit) begin
                    steps_r    <= 4'h0;
                    chip_rst_o <= 1'b1;
                end else begin
                    steps_r <= steps_r + 4'h1;
                end
            end
        end
    end

endmodule

//--- tb/wdg_checker.sv
// Port-level assertions for the watchdog block.
`timescale 1ns/100ps
module wdg_checker #(
    parameter TICK_DIV = 10
) (
    input wire        clk_i, rst_i, cyc_i, stb_i, we_i,
    input wire [7:0]  adr_i,
    input wire [3:0]  sel_i,
    input wire [31:0] dat_i, dat_o,
    input wire        ack_o, err_o, ddc2_set_i, ddc2_flag_o, chip_rst_o,
    input wire        divider_option_o
);
    wire    take = cyc_i & stb_i & ~ack_o & ~err_o;
    wire    wr80 = ack_o & we_i & (adr_i == 8'h80) & sel_i[0];
    reg     en_r;
    reg     arm_r;
    reg [3:0] lim_r;
    integer cnt_r;
    // The armed flag drops at a pulse so a design that fires only once is not punished.
    always @(posedge clk_i) begin
        if (rst_i) begin
            en_r <= 1'b0; arm_r <= 1'b0; lim_r <= 4'h8; cnt_r <= 0;
        end else if (wr80) begin
            en_r <= dat_i[7]; arm_r <= dat_i[7];
            // Only a kick or a start from idle restarts the period.
            cnt_r <= (dat_i[6] || !en_r) ? 0 : cnt_r + 1;
            lim_r <= (dat_i[2:0] == 3'h0) ? 4'h8 : {1'b0, dat_i[2:0]};
        end else if (chip_rst_o) begin
            arm_r <= 1'b0; cnt_r <= 0;
        end else if (en_r) begin
            cnt_r <= cnt_r + 1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_answer_next: assert property (take |=> ack_o || err_o)
        else $error("no answer one cycle after request");
    a_unmapped_err: assert property (take && adr_i != 8'h80 &&
        !(adr_i == 8'h84 && !we_i) |=> err_o && !ack_o)
        else $error("unmapped access not refused");
    a_ctrl_wo: assert property (take && !we_i && adr_i == 8'h80
        |=> ack_o && dat_o == 32'h0) else $error("control read not zero");
    a_flag_clear: assert property (wr80 && dat_i[5] && !ddc2_set_i
        && !$past(ddc2_set_i) |=> !ddc2_flag_o)
        else $error("flag not cleared");
    a_opt_stored: assert property (wr80 |=>
        divider_option_o == $past(dat_i[4])) else $error("option lost");
    a_no_rst_off: assert property (!en_r && !$past(en_r)
        |-> !chip_rst_o) else $error("reset while disabled");
    a_rst_early: assert property (chip_rst_o
        |-> cnt_r + 2 >= lim_r * TICK_DIV) else $error("overflow early");
    a_rst_late: assert property (arm_r
        |-> cnt_r <= lim_r * TICK_DIV + 2) else $error("overflow late");
    a_rst_pulse: assert property (chip_rst_o |=> !chip_rst_o)
        else $error("chip reset longer than one cycle");
    cover property (chip_rst_o);
    cover property (err_o);
    cover property (wr80 && dat_i[6]);
endmodule
bind wdg_top wdg_checker #(.TICK_DIV(TICK_DIV)) u_chk (.*);

//--- tb/wdg_top_test.sv
// Self-checking bench for the watchdog register and overflow reset.
`timescale 1ns/100ps
module wdg_top_test;
    localparam TD = 10;
    reg         clk_i = 1'b0, rst_i = 1'b1, ddc2_set_i = 1'b0;
    reg         cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    reg  [7:0]  adr_i = 8'h0;
    reg  [3:0]  sel_i = 4'h1;
    reg  [31:0] dat_i = 32'h0, q;
    wire [31:0] dat_o;
    wire        ack_o, err_o, ddc2_flag_o, chip_rst_o, opt_o;
    integer     fail_count = 0, comparisons = 0, i, c, hits = 0;
    wdg_top #(.TICK_DIV(TD)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .err_o(err_o), .ddc2_set_i(ddc2_set_i), .ddc2_flag_o(ddc2_flag_o),
        .chip_rst_o(chip_rst_o), .divider_option_o(opt_o));
    initial forever #2 clk_i = ~clk_i;
    always @(posedge clk_i) if (chip_rst_o === 1'b1) hits <= hits + 1;
    task chk(input [31:0] got, input [31:0] exp); begin
        comparisons = comparisons + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    end endtask
    // Error answers come back as all ones so a refusal is visible.
    task bus(input w, input [7:0] a, input [7:0] d); begin
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a;
        dat_i <= {24'h0, d};
        c = 0;
        do begin @(posedge clk_i); c = c + 1; end
        while (ack_o !== 1'b1 && err_o !== 1'b1);
        chk(c, 2);
        q = (err_o === 1'b1) ? 32'hffffffff : dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0;
    end endtask
    task final_report; begin
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    end endtask
    initial begin
        #40000 fail_count = fail_count + 1;
        final_report;
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, 8'h84, 8'h0); chk(q, 32'h0);
        bus(0, 8'h80, 8'h0); chk(q, 32'h0);
        bus(1, 8'h84, 8'h1); chk(q, 32'hffffffff);
        bus(0, 8'h90, 8'h0); chk(q, 32'hffffffff);
        @(posedge clk_i) ddc2_set_i <= 1'b1;
        @(posedge clk_i) ddc2_set_i <= 1'b0;
        bus(1, 8'h80, 8'h10); bus(0, 8'h84, 8'h0);
        chk(q, 32'h6);
        chk(opt_o, 32'h1);
        bus(1, 8'h80, 8'h20); bus(0, 8'h84, 8'h0); chk(q, 32'h0);
        // A control write without its byte lane must leave all fields alone.
        sel_i <= 4'h0;
        bus(1, 8'h80, 8'h90);
        sel_i <= 4'h1;
        bus(0, 8'h84, 8'h0);
        chk(q, 32'h0);
        for (i = 0; i < 8; i = i + 1) begin
            // The kick bit realigns the time base for each new interval.
            bus(1, 8'h80, 8'hc0 | i[2:0]);
            c = 0;
            while (chip_rst_o !== 1'b1 && c < 200) begin
                @(posedge clk_i); c = c + 1;
            end
            chk(c + 2 >= (i ? i : 8) * TD && c <= (i ? i : 8) * TD + 2,
                1);
        end
        bus(1, 8'h80, 8'h81); i = hits;
        repeat (8) bus(1, 8'h80, 8'hc1);
        chk(hits, i);
        bus(1, 8'h80, 8'h01); repeat (40) @(posedge clk_i);
        chk(hits, i);
        final_report;
    end
endmodule
